// ===== verilog/vectored_interrupt_exception_unit.sv
// Behaviour
// - handle 67 interrupt sources in total
// - three nmis, codes 0010H to 0030H
// - 64 maskable sources with own control register
// - eight programmable priority levels per source
// - preempt only by strictly higher level
// - masked maskable request is never acknowledged
// - 32 trap vectors, codes 004nH and 005nH
// - illegal opcode gives code and handler 0060H
// - exceptions are served before interrupts
// - reset vector code 0000H, pc undefined
// - source k code 0080H plus k times 10H
// - same level ties go to lowest number
// - save restored pc for nmis, and one shared by exceptions and maskables
// - nmi raised on rising input edge, lower of simultaneous edges dropped
`timescale 1ns/10ps
module vectored_interrupt_exception_unit
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // request pins
    input wire logic [vec_interrupt_control_unit_pkg::NUM_NMI-1:0] nonmaskable_request_input_in,
    input wire logic [vec_interrupt_control_unit_pkg::NUM_MASKABLE-1:0] maskable_request_input_in,
    // core events
    input wire logic trap_req_in,
    input wire logic [4:0] trap_vec_in,
    input wire logic illegal_opcode_trap_in,
    input wire logic int_enable_in,
    input wire logic ack_in,
    input wire logic retire_in,
    input wire logic [31:0] following_instruction_pc_in,
    // source control write
    input wire vec_interrupt_control_unit_pkg::ctrl_write_type ctrl_in,
    // offer to core
    output logic req_valid_out,
    output vec_interrupt_control_unit_pkg::vector_type vector_out,
    output logic [31:0] maskable_saved_pc_out,
    output logic [31:0] nonmaskable_saved_pc_out
);
    import vec_interrupt_control_unit_pkg::*;

    logic [NUM_NMI-1:0] nmi_s1_q, nmi_s2_q, nmi_s3_q;
    logic [NUM_MASKABLE-1:0] int_s1_q, int_s2_q, int_s3_q;
    logic [NUM_NMI-1:0] nmi_pend_q;
    logic [NUM_MASKABLE-1:0] int_pend_q;
    logic [NUM_MASKABLE-1:0] mask_q;
    logic [2:0] level_q [NUM_MASKABLE];
    logic trap_pend_q, ill_pend_q;
    logic [4:0] trap_vec_q;
    logic [NUM_LEVELS-1:0] isr_q;
    logic nmi_busy_q;
    state_type state_q;
    vector_type vec_q;
    logic [NUM_NMI-1:0] nmi_win_q;
    logic [5:0] win_idx_q;
    logic [2:0] win_level_q;
    logic [31:0] mpc_q, npc_q;

    wire [NUM_NMI-1:0] nmi_edge = nmi_s2_q & ~nmi_s3_q;
    wire [NUM_MASKABLE-1:0] int_edge = int_s2_q & ~int_s3_q;
    // only the highest of simultaneous nmi edges survives
    wire [NUM_NMI-1:0] nmi_first = nmi_edge[2] ? 3'h4 : (nmi_edge[1] ? 3'h2 : nmi_edge);
    wire take = (state_q == ST_OFFER) && ack_in;
    wire pick = (state_q == ST_IDLE);

    // threshold: level of highest-priority service in progress, 8 when none
    logic [3:0] thresh;
    logic m_found;
    logic [5:0] m_idx;
    logic [2:0] m_lvl;
    always_comb
    begin
        thresh = 4'h8;
        for (int l = NUM_LEVELS - 1; l >= 0; l--)
        begin
            if (isr_q[l])
            begin
                thresh = 4'(l);
            end
        end
        m_found = 1'b0;
        m_idx = 6'h00;
        m_lvl = 3'h7;
        for (int k = 0; k < NUM_MASKABLE; k++)
        begin
            // strict compare keeps the lower number on a tie
            if (int_pend_q[k] && !mask_q[k] && ({1'b0, level_q[k]} < thresh)
                && (!m_found || level_q[k] < m_lvl))
            begin
                m_found = 1'b1;
                m_idx = 6'(k);
                m_lvl = level_q[k];
            end
        end
    end

    wire m_ok = m_found && int_enable_in && !nmi_busy_q;
    wire [1:0] nmi_num = nmi_pend_q[2] ? 2'h2 : (nmi_pend_q[1] ? 2'h1 : 2'h0);
    wire [NUM_NMI-1:0] nmi_sel = nmi_pend_q[2] ? 3'h4 : (nmi_pend_q[1] ? 3'h2 : 3'h1);

    vector_type win;
    wire win_any = ill_pend_q || trap_pend_q || (|nmi_pend_q) || m_ok;
    always_comb
    begin
        win.restore = RESTORE_NEXT_PC;
        if (ill_pend_q)
        begin
            win.code = CODE_ILLEGAL;
            win.handler = HANDLER_ILLEGAL;
            win.cls = CLS_EXC;
        end
        else if (trap_pend_q)
        begin
            win.code = CODE_TRAP_BASE + {11'h000, trap_vec_q};
            win.handler = HANDLER_TRAP_BASE + {27'h0000000, trap_vec_q[4], 4'h0};
            win.cls = CLS_EXC;
        end
        else if (|nmi_pend_q)
        begin
            win.code = CODE_NMI_STEP * {14'h0000, nmi_num + 2'h1};
            win.handler = {16'h0000, CODE_NMI_STEP * {14'h0000, nmi_num + 2'h1}};
            win.cls = CLS_NMI;
        end
        else
        begin
            win.code = CODE_MASK_BASE + {6'h00, m_idx, 4'h0};
            win.handler = {16'h0000, CODE_MASK_BASE + {6'h00, m_idx, 4'h0}};
            win.cls = CLS_MASK;
        end
    end

    // input synchronisers and edge memory
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            nmi_s1_q <= '0;
            nmi_s2_q <= '0;
            nmi_s3_q <= '0;
            int_s1_q <= '0;
            int_s2_q <= '0;
            int_s3_q <= '0;
        end
        else
        begin
            nmi_s1_q <= nonmaskable_request_input_in;
            nmi_s2_q <= nmi_s1_q;
            nmi_s3_q <= nmi_s2_q;
            int_s1_q <= maskable_request_input_in;
            int_s2_q <= int_s1_q;
            int_s3_q <= int_s2_q;
        end
    end

    // per-source control registers
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            mask_q <= {NUM_MASKABLE{MASK_RESET}};
            for (int k = 0; k < NUM_MASKABLE; k++)
            begin
                level_q[k] <= LEVEL_RESET;
            end
        end
        else if (ctrl_in.wr)
        begin
            mask_q[ctrl_in.sel] <= ctrl_in.mask;
            level_q[ctrl_in.sel] <= ctrl_in.level;
        end
    end

    // pending flags: a new edge beats the clear on acknowledge
    wire [NUM_NMI-1:0] nmi_clr = (take && vec_q.cls == CLS_NMI) ? nmi_win_q : 3'h0;
    wire [NUM_MASKABLE-1:0] int_clr = (take && vec_q.cls == CLS_MASK) ? (64'h1 << win_idx_q) : 64'h0;
    wire exc_take = take && vec_q.cls == CLS_EXC;
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            nmi_pend_q <= '0;
            int_pend_q <= '0;
            ill_pend_q <= 1'b0;
            trap_pend_q <= 1'b0;
            trap_vec_q <= 5'h00;
        end
        else
        begin
            nmi_pend_q <= (nmi_pend_q & ~nmi_clr) | nmi_first;
            int_pend_q <= (int_pend_q & ~int_clr) | int_edge;
            ill_pend_q <= (ill_pend_q & ~(exc_take && vec_q.code == CODE_ILLEGAL)) | illegal_opcode_trap_in;
            trap_pend_q <= (trap_pend_q & ~(exc_take && vec_q.code != CODE_ILLEGAL)) | trap_req_in;
            if (trap_req_in)
            begin
                trap_vec_q <= trap_vec_in;
            end
        end
    end

    // offer, hold until acknowledged, then save pc and track service
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_q <= ST_IDLE;
            vec_q <= '{CODE_RESET, HANDLER_RESET, CLS_RESET, RESTORE_UNDEFINED};
            nmi_win_q <= '0;
            win_idx_q <= 6'h00;
            win_level_q <= 3'h0;
            mpc_q <= PC_RESET;
            npc_q <= PC_RESET;
            isr_q <= '0;
            nmi_busy_q <= 1'b0;
        end
        else
        begin
            if (pick && win_any)
            begin
                state_q <= ST_OFFER;
                vec_q <= win;
                nmi_win_q <= nmi_sel;
                win_idx_q <= m_idx;
                win_level_q <= m_lvl;
            end
            else if (take)
            begin
                state_q <= ST_IDLE;
            end
            if (take && vec_q.cls == CLS_NMI)
            begin
                npc_q <= following_instruction_pc_in;
            end
            if (take && vec_q.cls != CLS_NMI)
            begin
                mpc_q <= following_instruction_pc_in;
            end
            if (take && vec_q.cls == CLS_NMI)
            begin
                nmi_busy_q <= 1'b1;
            end
            else if (retire_in && nmi_busy_q)
            begin
                nmi_busy_q <= 1'b0;
            end
            if (take && vec_q.cls == CLS_MASK)
            begin
                isr_q[win_level_q] <= 1'b1;
            end
            else if (retire_in && !nmi_busy_q && thresh != 4'h8)
            begin
                isr_q[thresh[2:0]] <= 1'b0;
            end
        end
    end

    assign req_valid_out = (state_q == ST_OFFER);
    assign vector_out = vec_q;
    assign maskable_saved_pc_out = mpc_q;
    assign nonmaskable_saved_pc_out = npc_q;

    property p_nmi_edge;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        nmi_edge[0] && !nmi_edge[1] && !nmi_edge[2] |=> nmi_pend_q[0];
    endproperty
    a_nmi_edge: assert property (p_nmi_edge) else $error("nmi edge lost");

    property p_nmi_ignore;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        nmi_edge[2] && nmi_edge[0] && !nmi_pend_q[0] |=> !nmi_pend_q[0];
    endproperty
    a_nmi_ignore: assert property (p_nmi_ignore) else $error("lower nmi not ignored");

    property p_hold;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        req_valid_out && !ack_in |=> req_valid_out && $stable(vector_out);
    endproperty
    a_hold: assert property (p_hold) else $error("offer changed before ack");

    property p_exc_first;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        pick && ill_pend_q |=> vector_out.code == 16'h0060 && vector_out.handler == 32'h00000060;
    endproperty
    a_exc_first: assert property (p_exc_first) else $error("exception not first");

    property p_masked;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        $rose(req_valid_out) && vector_out.cls == CLS_MASK |-> !$past(mask_q[m_idx]);
    endproperty
    a_masked: assert property (p_masked) else $error("masked source offered");

    property p_mask_code;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        req_valid_out && vector_out.cls == CLS_MASK |->
            vector_out.code == 16'h0080 + 16'(win_idx_q) * 16'h0010 && vector_out.handler[15:0] == vector_out.code;
    endproperty
    a_mask_code: assert property (p_mask_code) else $error("maskable vector wrong");

    property p_nmi_save;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        take && vector_out.cls == CLS_NMI |=> nonmaskable_saved_pc_out == $past(following_instruction_pc_in);
    endproperty
    a_nmi_save: assert property (p_nmi_save) else $error("nmi pc not saved");

    property p_reset_vec;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        vector_out.cls == CLS_RESET |-> vector_out.code == 16'h0000 && vector_out.handler == 32'h0
            && vector_out.restore == RESTORE_UNDEFINED;
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("reset vector wrong");

    property p_trap_code;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        pick && trap_pend_q && !ill_pend_q |=>
            vector_out.code == 16'h0040 + 16'($past(trap_vec_q)) && vector_out.cls == CLS_EXC;
    endproperty
    a_trap_code: assert property (p_trap_code) else $error("trap code wrong");

    property p_cov_nmi;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        take && vector_out.cls == CLS_NMI;
    endproperty
    c_cov_nmi: cover property (p_cov_nmi);

    property p_cov_nest;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        take && vector_out.cls == CLS_MASK && isr_q != 8'h00;
    endproperty
    c_cov_nest: cover property (p_cov_nest);

    property p_cov_trap;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        take && vector_out.cls == CLS_EXC && vector_out.code[4];
    endproperty
    c_cov_trap: cover property (p_cov_trap);
endmodule

// ===== common/vec_interrupt_control_unit_pkg.sv
package vec_interrupt_control_unit_pkg;
    localparam int NUM_MASKABLE = 64;
    localparam int NUM_NMI = 3;
    localparam int NUM_LEVELS = 8;
    localparam logic [2:0] LEVEL_RESET = 3'h7;
    localparam logic MASK_RESET = 1'b1;
    localparam logic [15:0] CODE_RESET = 16'h0000;
    localparam logic [31:0] HANDLER_RESET = 32'h00000000;
    localparam logic [15:0] CODE_NMI_STEP = 16'h0010;
    localparam logic [15:0] CODE_TRAP_BASE = 16'h0040;
    localparam logic [31:0] HANDLER_TRAP_BASE = 32'h00000040;
    localparam logic [15:0] CODE_ILLEGAL = 16'h0060;
    localparam logic [31:0] HANDLER_ILLEGAL = 32'h00000060;
    localparam logic [15:0] CODE_MASK_BASE = 16'h0080;
    localparam logic [31:0] PC_RESET = 32'h00000000;

    typedef enum logic [1:0] {
        CLS_RESET = 2'b00,
        CLS_NMI = 2'b01,
        CLS_EXC = 2'b10,
        CLS_MASK = 2'b11
    } class_type;

    typedef enum logic {
        RESTORE_UNDEFINED = 1'b0,
        RESTORE_NEXT_PC = 1'b1
    } restore_type;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_OFFER = 1'b1
    } state_type;

    typedef struct packed {
        logic [15:0] code;
        logic [31:0] handler;
        class_type cls;
        restore_type restore;
    } vector_type;

    typedef struct packed {
        logic wr;
        logic [5:0] sel;
        logic [2:0] level;
        logic mask;
    } ctrl_write_type;
endpackage

// ===== testbench/core_model.sv
`timescale 1ns/10ps
module core_model
(
    // clock
    input wire logic clk_sys_in,
    // offer from the unit, ack delay from the bench
    input wire logic req_valid_in,
    input wire vec_interrupt_control_unit_pkg::vector_type vector_in,
    input wire logic [3:0] ack_delay_in,
    // answer to the unit
    output logic ack_out,
    output logic [31:0] pc_out,
    // record of accepted offers
    output vec_interrupt_control_unit_pkg::vector_type taken_out,
    output logic [31:0] taken_pc_out,
    output int taken_count_out
);
    import vec_interrupt_control_unit_pkg::*;
    int wait_cnt;
    initial
    begin
        ack_out = 1'b0;
        pc_out = 32'h00001000;
        taken_out = '0;
        taken_pc_out = '0;
        taken_count_out = 0;
        wait_cnt = 0;
    end
    // ack a standing offer after the chosen delay, pc moves every cycle
    always @(negedge clk_sys_in)
    begin
        pc_out <= pc_out + 32'h00000004;
        if (req_valid_in === 1'b1 && ack_out === 1'b0 && wait_cnt >= int'(ack_delay_in))
        begin
            ack_out <= 1'b1;
            wait_cnt <= 0;
        end
        else if (req_valid_in === 1'b1 && ack_out === 1'b0)
            wait_cnt <= wait_cnt + 1;
        else
            ack_out <= 1'b0;
    end
    always @(posedge clk_sys_in)
    begin
        if (ack_out === 1'b1 && req_valid_in === 1'b1)
        begin
            taken_out <= vector_in;
            taken_pc_out <= pc_out;
            taken_count_out <= taken_count_out + 1;
        end
    end
endmodule

// ===== testbench/vectored_interrupt_exception_unit_tb.sv
`timescale 1ns/10ps
module vectored_interrupt_exception_unit_tb;
    import vec_interrupt_control_unit_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [2:0] nmi_pins = '0;
    logic [63:0] mask_pins = '0;
    logic trap_req = 1'b0;
    logic [4:0] trap_vec = '0;
    logic illegal = 1'b0;
    logic int_en = 1'b0;
    logic retire = 1'b0;
    ctrl_write_type ctrl = '0;
    logic [3:0] ack_delay = '0;
    logic ack;
    logic valid;
    logic [31:0] pc;
    logic [31:0] mpc;
    logic [31:0] npc;
    logic [31:0] tpc;
    vector_type vec;
    vector_type taken;
    int taken_count;
    int mismatches = 0;
    int samples_checked = 0;
    int n_exp = 0;
    initial
    begin
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    vectored_interrupt_exception_unit i_vectored_interrupt_exception_unit (.clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in), .nonmaskable_request_input_in(nmi_pins), .maskable_request_input_in(mask_pins),
        .trap_req_in(trap_req), .trap_vec_in(trap_vec), .illegal_opcode_trap_in(illegal), .int_enable_in(int_en),
        .ack_in(ack), .retire_in(retire), .following_instruction_pc_in(pc), .ctrl_in(ctrl),
        .req_valid_out(valid), .vector_out(vec), .maskable_saved_pc_out(mpc), .nonmaskable_saved_pc_out(npc));
    core_model i_core_model (.clk_sys_in(clk_sys_in), .req_valid_in(valid), .vector_in(vec),
        .ack_delay_in(ack_delay), .ack_out(ack), .pc_out(pc), .taken_out(taken), .taken_pc_out(tpc),
        .taken_count_out(taken_count));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [50:0] seen, input logic [50:0] want, input string what);
        samples_checked++;
        if (seen !== want)
        begin
            mismatches++;
            $display("wrong value at %0t: %s seen %h want %h", $time, what, seen, want);
        end
    endtask
    function automatic vector_type mk(input logic [15:0] code, input logic [31:0] hdl, input class_type cls);
        return {code, hdl, cls, RESTORE_NEXT_PC};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    task automatic got(input vector_type want);
        int i;
        n_exp++;
        for (i = 0; i < 60 && taken_count < n_exp; i++)
            tick(1);
        if (taken_count < n_exp)
        begin
            mismatches++;
            $display("wrong value at %0t: offer never came", $time);
            give_verdict();
        end
        check(taken, want, "accepted vector");
    endtask
    task automatic none(input int n);
        tick(n);
        check(51'(taken_count), 51'(n_exp), "offer count");
    endtask
    task automatic pins(input logic [63:0] m, input logic [2:0] n);
        mask_pins = m;
        nmi_pins = n;
        tick(4);
        mask_pins = '0;
        nmi_pins = '0;
    endtask
    task automatic cw(input logic [5:0] sel, input logic [2:0] lvl, input logic m);
        ctrl = {1'b1, sel, lvl, m};
        tick(1);
        ctrl = '0;
    endtask
    task automatic ret();
        retire = 1'b1;
        tick(1);
        retire = 1'b0;
        tick(2);
    endtask
    task automatic t_reset();
        check(vec, {CODE_RESET, HANDLER_RESET, CLS_RESET, RESTORE_UNDEFINED}, "reset vector");
        check(51'(valid), 51'(0), "idle offer");
        $display("test reset done");
    endtask
    task automatic t_nmi();
        int n;
        for (n = 0; n < 3; n++)
        begin
            pins('0, 3'(1 << n));
            got(mk(16'h0010 * 16'(n + 1), 32'h00000010 * 32'(n + 1), CLS_NMI));
            check(51'(npc), 51'(tpc), "nmi saved pc");
            ret();
        end
        pins('0, 3'h7);
        got(mk(16'h0030, 32'h00000030, CLS_NMI));
        ret();
        none(20);
        $display("test nmi done");
    endtask
    task automatic t_mask();
        int_en = 1'b1;
        pins(64'h0000000000000008, '0);
        none(20);
        cw(6'h03, 3'h2, 1'b0);
        got(mk(16'h00B0, 32'h000000B0, CLS_MASK));
        check(51'(mpc), 51'(tpc), "maskable saved pc");
        ret();
        cw(6'h05, 3'h2, 1'b0);
        pins(64'h0000000000000028, '0);
        got(mk(16'h00B0, 32'h000000B0, CLS_MASK));
        none(20);
        cw(6'h3F, 3'h0, 1'b0);
        pins(64'h8000000000000000, '0);
        got(mk(16'h0470, 32'h00000470, CLS_MASK));
        ret();
        none(20);
        ret();
        got(mk(16'h00D0, 32'h000000D0, CLS_MASK));
        ret();
        int_en = 1'b0;
        pins(64'h0000000000000008, 3'h1);
        got(mk(16'h0010, 32'h00000010, CLS_NMI));
        ret();
        none(20);
        int_en = 1'b1;
        got(mk(16'h00B0, 32'h000000B0, CLS_MASK));
        ret();
        $display("test maskable done");
    endtask
    task automatic trap(input logic [4:0] v);
        trap_vec = v;
        trap_req = 1'b1;
        tick(1);
        trap_req = 1'b0;
    endtask
    task automatic t_exc();
        int v;
        for (v = 0; v < 32; v++)
        begin
            ack_delay = 4'(v % 4 * 3);
            trap(5'(v));
            got(mk(16'h0040 + 16'(v), v < 16 ? 32'h00000040 : 32'h00000050, CLS_EXC));
        end
        ack_delay = 4'hC;
        trap(5'h00);
        illegal = 1'b1;
        tick(1);
        illegal = 1'b0;
        pins(64'h0000000000000008, '0);
        check(vec, mk(16'h0040, 32'h00000040, CLS_EXC), "held offer");
        got(mk(16'h0040, 32'h00000040, CLS_EXC));
        ack_delay = '0;
        got(mk(16'h0060, 32'h00000060, CLS_EXC));
        check(51'(mpc), 51'(tpc), "exception saved pc");
        got(mk(16'h00B0, 32'h000000B0, CLS_MASK));
        ret();
        $display("test exception done");
    endtask
    initial
    begin
        repeat (8) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        tick(2);
        t_reset();
        t_nmi();
        t_mask();
        t_exc();
        give_verdict();
    end
endmodule
